// ==== core/sms_pkg.sv ====
// Package for the standby mode sequencer: register map, field positions,
// reset values and the sequencer state type.
// Assumes a 32-bit APB register bus with byte addresses in paddr.
package sms_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] PDC_OFS = 12'h000;
  localparam logic [11:0] ICR_OFS = 12'h004;
  localparam logic [11:0] WCS_OFS = 12'h008;
  localparam logic [11:0] WRC_OFS = 12'h00c;
  localparam logic [11:0] WCNT_OFS = 12'h010;
  localparam logic [11:0] STAT_OFS = 12'h014;

  // ==========================================================================
  // Field positions
  localparam int PDC_SBY_BIT = 7;
  localparam int PDC_HIZ_BIT = 6;
  localparam int ICR_POL_BIT = 0;
  localparam int WCS_OVF_BIT = 7;
  localparam int WCS_MODE_BIT = 6;
  localparam int WCS_RUN_BIT = 5;
  localparam int STAT_SBY_BIT = 0;
  localparam int STAT_WARM_BIT = 1;

  // ==========================================================================
  // Reset and read-back values
  localparam logic [4:0] PDC_LOW_ONES = 5'h1f;
  localparam logic [7:0] PDC_RST = 8'h1f;
  localparam logic [7:0] WRC_RST = 8'h00;
  localparam logic [7:0] WCNT_MAX = 8'hff;

  // ==========================================================================
  // Peripheral groups that standby initialises
  localparam int PI_DTC = 0;
  localparam int PI_DMA = 1;
  localparam int PI_SCI = 2;
  localparam int PI_ADC = 3;
  localparam int PI_CMT = 4;
  localparam int PI_MTU = 5;
  localparam int PI_W = 6;

  // ==========================================================================
  // Sequencer state
  typedef enum logic [1:0] {
    SMS_RUN,
    SMS_STANDBY,
    SMS_WARMUP
  } sms_state_t;

endpackage

// ==== core/sms_standby_sequencer.sv ====
// Standby mode sequencer: power-down control, watchdog timing for the NMI
// exit, clock and halt controls, and peripheral initialise strobes.
// Assumes pclk is the free-running oscillator and all inputs are
// synchronous to it; the gated system clock is represented by sys_clk_en.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RULE1 - Sleep instruction with standby select set enters standby.
// RULE2 - Standby stops system clock, CPU and all peripherals.
// RULE3 - CPU registers and RAM keep contents throughout standby.
// RULE4 - Port pins hold levels or float during standby, per float bit.
// RULE5 - Entry initialises transfer controller registers except its data register.
// RULE6 - Entry initialises DMA channel control and operation registers.
// RULE7 - Entry clears watchdog flag, mode, run and reset control; keeps rest.
// RULE8 - Entry initialises serial, A/D converter and compare timer registers.
// RULE9 - Entry initialises multifunction timer; output enable registers kept.
// RULE10 - Interrupt, break, cache, bus, pin, port and power registers kept.
// RULE11 - Only NMI, power-on reset or manual reset end standby.
// RULE12 - Selected NMI edge restarts oscillation, clocking only the watchdog.
// RULE13 - Watchdog overflow releases the chip and starts NMI exception.
// RULE14 - Software picks a watchdog period longer than oscillator settling.
// RULE15 - Falling edge mode: NMI high on entry, low at resume.
// RULE16 - Rising edge mode: NMI low on entry, high at resume.
// RULE17 - Power-on reset pin low ends standby by power-on reset.
// RULE18 - Edge polarity bit 0 selects falling, 1 selects rising.
// RULE19 - Handler sets rising edge, standby select, then sleeps.
// RULE20 - Standby select cannot be set while watchdog run bit is 1.
// RULE21 - Float bit 0 holds pins, 1 places them at high impedance.
// RULE22 - NMI edge detector works with the system clock stopped.
module sms_standby_sequencer #(
  parameter int PRE_W = 16
) (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU and pins
  input wire logic cpu_sleep_exec,
  input wire logic nmi_pin,
  input wire logic manual_reset_n,
  // Clock and halt controls
  output logic sys_clk_en,
  output logic wdt_clk_en,
  output logic cpu_halt,
  output logic periph_halt,
  output logic standby_active,
  output logic nmi_exception,
  // Port pin control
  output logic port_hold,
  output logic port_float,
  // Peripheral initialise strobes
  output logic [sms_pkg::PI_W-1:0] periph_init
);

  // ==========================================================================
  // State
  typedef struct packed {
    sms_pkg::sms_state_t state;
    logic standby_select_bit;
    logic port_float_bit;
    logic nmi_pol;
    logic wd_ovf;
    logic wd_mode;
    logic wd_run;
    logic [2:0] wd_cks;
    logic [7:0] wd_rst;
    logic [7:0] wd_cnt;
    logic [PRE_W-1:0] wd_pre;
    logic nmi_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sys_clk_en;
    logic wdt_clk_en;
    logic cpu_halt;
    logic periph_halt;
    logic nmi_exc;
    logic port_hold;
    logic port_float;
    logic [sms_pkg::PI_W-1:0] periph_init;
  } sms_regs_t;

  sms_regs_t r_q;
  sms_regs_t r_d;

  // ==========================================================================
  // Helpers

  // A prescaler tick comes every 2**(cks+1) oscillator cycles.
  function automatic logic wd_tick(input logic [PRE_W-1:0] pre,
                                   input logic [2:0] cks);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((32'h2 << cks) - 32'h1);
    return (pre & mask) == mask;
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    return a == sms_pkg::PDC_OFS || a == sms_pkg::ICR_OFS ||
           a == sms_pkg::WCS_OFS || a == sms_pkg::WRC_OFS ||
           a == sms_pkg::WCNT_OFS || a == sms_pkg::STAT_OFS;
  endfunction

  // ==========================================================================
  // Next state
  logic access;
  logic hit;
  logic nmi_edge;
  logic counting;
  logic tick;
  logic overflow;
  logic [31:0] rd_val;

  always_comb begin
    r_d = r_q;
    r_d.nmi_exc = 1'b0;
    r_d.periph_init = '0;
    access = psel && penable;
    hit = reg_hit(paddr);

    // Read mux.
    rd_val = 32'h0000_0000;
    case (paddr)
      sms_pkg::PDC_OFS: begin
        rd_val = {24'h00_0000, r_q.standby_select_bit, r_q.port_float_bit, 1'b0,
                  sms_pkg::PDC_LOW_ONES};
      end
      sms_pkg::ICR_OFS: begin
        rd_val[sms_pkg::ICR_POL_BIT] = r_q.nmi_pol;
      end
      sms_pkg::WCS_OFS: begin
        rd_val = {24'h00_0000, r_q.wd_ovf, r_q.wd_mode, r_q.wd_run,
                  2'b00, r_q.wd_cks};
      end
      sms_pkg::WRC_OFS: begin
        rd_val = {24'h00_0000, r_q.wd_rst};
      end
      sms_pkg::WCNT_OFS: begin
        rd_val = {24'h00_0000, r_q.wd_cnt};
      end
      sms_pkg::STAT_OFS: begin
        rd_val[sms_pkg::STAT_SBY_BIT] = r_q.state != sms_pkg::SMS_RUN;
        rd_val[sms_pkg::STAT_WARM_BIT] = r_q.state == sms_pkg::SMS_WARMUP;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase

    // APB: answer one cycle into the access phase, write at the final edge.
    if (access && !r_q.pready) begin
      r_d.pready = 1'b1;
      r_d.prdata = rd_val;
      r_d.pslverr = !hit;
    end else begin
      r_d.pready = 1'b0;
      r_d.pslverr = 1'b0;
    end
    if (access && r_q.pready && pwrite && hit &&
        r_q.state == sms_pkg::SMS_RUN) begin
      case (paddr)
        sms_pkg::PDC_OFS: begin
          // Neither bit may be raised while the watchdog runs.
          if (!r_q.wd_run) begin // RULE20
            r_d.standby_select_bit = pwdata[sms_pkg::PDC_SBY_BIT]; // RULE1
            r_d.port_float_bit = pwdata[sms_pkg::PDC_HIZ_BIT]; // RULE21
          end else begin
            r_d.standby_select_bit = r_q.standby_select_bit && pwdata[sms_pkg::PDC_SBY_BIT];
            r_d.port_float_bit = r_q.port_float_bit && pwdata[sms_pkg::PDC_HIZ_BIT];
          end
        end
        sms_pkg::ICR_OFS: begin
          r_d.nmi_pol = pwdata[sms_pkg::ICR_POL_BIT]; // RULE18
        end
        sms_pkg::WCS_OFS: begin
          r_d.wd_ovf = r_q.wd_ovf && pwdata[sms_pkg::WCS_OVF_BIT];
          r_d.wd_mode = pwdata[sms_pkg::WCS_MODE_BIT];
          r_d.wd_run = pwdata[sms_pkg::WCS_RUN_BIT];
          r_d.wd_cks = pwdata[2:0];
        end
        sms_pkg::WRC_OFS: begin
          r_d.wd_rst = pwdata[7:0];
        end
        sms_pkg::WCNT_OFS: begin
          r_d.wd_cnt = pwdata[7:0];
        end
        default: begin
          r_d.wd_rst = r_q.wd_rst;
        end
      endcase
    end

    // NMI edge detection runs on the oscillator, not the gated clock.
    r_d.nmi_prev = nmi_pin; // RULE22
    nmi_edge = r_q.nmi_pol ? (nmi_pin && !r_q.nmi_prev)
                           : (!nmi_pin && r_q.nmi_prev); // RULE18

    // Watchdog counter; it stands still through standby itself.
    counting = (r_q.state == sms_pkg::SMS_RUN && r_q.wd_run) ||
               r_q.state == sms_pkg::SMS_WARMUP;
    tick = counting && wd_tick(r_q.wd_pre, r_q.wd_cks);
    overflow = tick && r_q.wd_cnt == sms_pkg::WCNT_MAX;
    if (counting) begin
      r_d.wd_pre = r_q.wd_pre + PRE_W'(1);
    end
    if (tick) begin
      r_d.wd_cnt = r_q.wd_cnt + 8'h01;
    end
    // A hardware overflow wins over a clear written in the same cycle.
    if (overflow && r_q.state == sms_pkg::SMS_RUN) begin
      r_d.wd_ovf = 1'b1;
    end

    case (r_q.state)
      sms_pkg::SMS_RUN: begin
        if (cpu_sleep_exec && r_q.standby_select_bit) begin // RULE1
          r_d.state = sms_pkg::SMS_STANDBY;
          r_d.sys_clk_en = 1'b0; // RULE2
          r_d.cpu_halt = 1'b1; // RULE3
          r_d.periph_halt = 1'b1; // RULE2
          r_d.port_hold = !r_q.port_float_bit; // RULE4
          r_d.port_float = r_q.port_float_bit; // RULE21
          // Only the listed groups are initialised; the interrupt, break,
          // cache, bus, pin function and port blocks get no strobe.
          r_d.periph_init[sms_pkg::PI_DTC] = 1'b1; // RULE5
          r_d.periph_init[sms_pkg::PI_DMA] = 1'b1; // RULE6
          r_d.periph_init[sms_pkg::PI_SCI] = 1'b1; // RULE8
          r_d.periph_init[sms_pkg::PI_ADC] = 1'b1; // RULE8
          r_d.periph_init[sms_pkg::PI_CMT] = 1'b1; // RULE8
          r_d.periph_init[sms_pkg::PI_MTU] = 1'b1; // RULE9
          r_d.wd_ovf = 1'b0; // RULE7
          r_d.wd_mode = 1'b0; // RULE7
          r_d.wd_run = 1'b0; // RULE7
          r_d.wd_rst = sms_pkg::WRC_RST; // RULE7
          // Power-down and edge select bits stay as written.
          r_d.standby_select_bit = r_q.standby_select_bit; // RULE10
          r_d.pready = 1'b0;
        end
      end
      sms_pkg::SMS_STANDBY: begin
        if (!manual_reset_n) begin // RULE11
          r_d.state = sms_pkg::SMS_RUN;
        end else if (nmi_edge) begin // RULE12
          r_d.state = sms_pkg::SMS_WARMUP;
          r_d.wdt_clk_en = 1'b1; // RULE12
        end
      end
      sms_pkg::SMS_WARMUP: begin
        if (!manual_reset_n) begin // RULE11
          r_d.state = sms_pkg::SMS_RUN;
        end else if (overflow) begin // RULE13
          r_d.state = sms_pkg::SMS_RUN;
          r_d.nmi_exc = 1'b1; // RULE13
        end
      end
      default: begin
        r_d.state = sms_pkg::SMS_RUN;
      end
    endcase

    // Leaving standby restores every clock and releases the pins.
    if (r_q.state != sms_pkg::SMS_RUN && r_d.state == sms_pkg::SMS_RUN) begin
      r_d.sys_clk_en = 1'b1; // RULE13
      r_d.wdt_clk_en = 1'b1;
      r_d.cpu_halt = 1'b0;
      r_d.periph_halt = 1'b0;
      r_d.port_hold = 1'b0;
      r_d.port_float = 1'b0;
    end
    if (r_q.state == sms_pkg::SMS_RUN &&
        r_d.state == sms_pkg::SMS_STANDBY) begin
      r_d.wdt_clk_en = 1'b0;
    end
  end

  // ==========================================================================
  // Registers; power-on reset also ends standby.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // RULE17
      r_q <= '{
        state: sms_pkg::SMS_RUN,
        standby_select_bit: sms_pkg::PDC_RST[sms_pkg::PDC_SBY_BIT],
        port_float_bit: sms_pkg::PDC_RST[sms_pkg::PDC_HIZ_BIT],
        wd_rst: sms_pkg::WRC_RST,
        sys_clk_en: 1'b1,
        wdt_clk_en: 1'b1,
        default: '0
      };
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign sys_clk_en = r_q.sys_clk_en;
  assign wdt_clk_en = r_q.wdt_clk_en;
  assign cpu_halt = r_q.cpu_halt;
  assign periph_halt = r_q.periph_halt;
  assign standby_active = r_q.cpu_halt;
  assign nmi_exception = r_q.nmi_exc;
  assign port_hold = r_q.port_hold;
  assign port_float = r_q.port_float;
  assign periph_init = r_q.periph_init;

endmodule

`default_nettype wire

// ==== sim/sms_cpu_pins.sv ====
// Model of the CPU sleep strobe and the NMI and manual reset pins.
// Assumes the bench calls its tasks; pins change after rising edges.
`timescale 1ns/1ns
`default_nettype none
module sms_cpu_pins (
  // Clock
  input wire logic pclk,
  // Pins
  output logic cpu_sleep_exec,
  output logic nmi_pin,
  output logic manual_reset_n
);
  initial begin
    cpu_sleep_exec = 1'b0;
    nmi_pin = 1'b0;
    manual_reset_n = 1'b1;
  end
  // The sleep instruction is a one-cycle strobe.
  task sleep;
    @(posedge pclk);
    cpu_sleep_exec <= 1'b1;
    @(posedge pclk);
    cpu_sleep_exec <= 1'b0;
  endtask
  task set_nmi(input logic v);
    @(posedge pclk);
    nmi_pin <= v;
  endtask
  task mreset;
    @(posedge pclk);
    manual_reset_n <= 1'b0;
    @(posedge pclk);
    manual_reset_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== sim/sms_standby_sva.sv ====
// Checker for the standby sequencer's clock, halt, pin and init outputs.
// Assumes it is bound to sms_standby_sequencer and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module sms_standby_sva (
  // Clock, reset and pins
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_sleep_exec,
  input wire logic nmi_pin,
  input wire logic manual_reset_n,
  // Controls
  input wire logic sys_clk_en,
  input wire logic wdt_clk_en,
  input wire logic cpu_halt,
  input wire logic periph_halt,
  input wire logic nmi_exception,
  input wire logic port_hold,
  input wire logic port_float,
  input wire logic [sms_pkg::PI_W-1:0] periph_init
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_enter;
    !cpu_halt ##1 cpu_halt;
  endsequence
  property p_enter;
    s_enter |-> $past(cpu_sleep_exec);
  endproperty
  property p_halt;
    cpu_halt |-> !sys_clk_en && periph_halt;
  endproperty
  property p_init;
    s_enter |-> periph_init == '1;
  endproperty
  property p_init_once;
    periph_init != '0 |-> $rose(cpu_halt);
  endproperty
  property p_pins;
    port_hold || port_float |-> cpu_halt && (port_hold != port_float);
  endproperty
  property p_stay;
    cpu_halt && !wdt_clk_en && manual_reset_n && $stable(nmi_pin)
      |=> cpu_halt && !wdt_clk_en;
  endproperty
  property p_manual_reset_pin;
    cpu_halt && !manual_reset_n |=> !cpu_halt && !nmi_exception;
  endproperty
  property p_exit;
    nmi_exception |-> $fell(cpu_halt) && sys_clk_en ##1 !nmi_exception;
  endproperty
  property p_wake;
    $rose(wdt_clk_en) && cpu_halt |-> $past(nmi_pin) != $past(nmi_pin, 2);
  endproperty
  a_enter: assert property (p_enter) else $error("halt without sleep");
  a_halt: assert property (p_halt) else $error("clock runs in halt");
  a_init: assert property (p_init) else $error("init strobes missing");
  a_init_once: assert property (p_init_once) else $error("stray init");
  a_pins: assert property (p_pins) else $error("port control wrong");
  a_stay: assert property (p_stay) else $error("standby left early");
  a_manual_reset_pin: assert property (p_manual_reset_pin) else $error("manual reset exit");
  a_exit: assert property (p_exit) else $error("nmi exit wrong");
  a_wake: assert property (p_wake) else $error("wake without edge");
endmodule
bind sms_standby_sequencer sms_standby_sva u_sva (
  .pclk(pclk), .presetn(presetn), .cpu_sleep_exec(cpu_sleep_exec),
  .nmi_pin(nmi_pin), .manual_reset_n(manual_reset_n),
  .sys_clk_en(sys_clk_en), .wdt_clk_en(wdt_clk_en), .cpu_halt(cpu_halt),
  .periph_halt(periph_halt), .nmi_exception(nmi_exception),
  .port_hold(port_hold), .port_float(port_float),
  .periph_init(periph_init));
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the standby sequencer over APB.
// Assumes the checker is bound in and sms_cpu_pins drives the pins.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, port_float_bit;
  logic cpu_sleep_exec, nmi_pin, manual_reset_n, nmi_exception;
  logic sys_clk_en, wdt_clk_en, cpu_halt, periph_halt, standby_active;
  logic port_hold, port_float;
  logic [sms_pkg::PI_W-1:0] periph_init;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pdc;
  logic [7:0] wc;
  logic [2:0] cks;
  int fails, n_compared, cyc, n, e;
  sms_standby_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_sleep_exec(cpu_sleep_exec), .nmi_pin(nmi_pin),
    .manual_reset_n(manual_reset_n), .sys_clk_en(sys_clk_en),
    .wdt_clk_en(wdt_clk_en), .cpu_halt(cpu_halt), .periph_halt(periph_halt),
    .standby_active(standby_active), .nmi_exception(nmi_exception),
    .port_hold(port_hold), .port_float(port_float), .periph_init(periph_init));
  sms_cpu_pins cpu (.pclk(pclk), .cpu_sleep_exec(cpu_sleep_exec),
    .nmi_pin(nmi_pin), .manual_reset_n(manual_reset_n));
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      fails++;
      finish_test;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task finish_test;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, x);
  endtask
  function automatic int exp_cyc(logic [7:0] w, logic [2:0] c);
    return (256 - w) << (c + 1);
  endfunction
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(29));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(sms_pkg::PDC_OFS, 32'h0000_001f);
    rdc(12'hffc, 32'h0000_0000);
    chk(er, 1'b1);
    cpu.sleep;
    repeat (2) @(posedge pclk);
    #1 chk(cpu_halt, 1'b0);
    // A running watchdog overflows and sets its flag; writing 0 clears it.
    wr(sms_pkg::WCNT_OFS, 32'h0000_00fe);
    wr(sms_pkg::WCS_OFS, 32'h0000_0020);
    repeat (8) @(posedge pclk);
    rdc(sms_pkg::WCS_OFS, 32'h0000_00a0);
    wr(sms_pkg::WCS_OFS, 32'h0000_0000);
    rdc(sms_pkg::WCS_OFS, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      port_float_bit = 1'($urandom % 2);
      cks = 3'($urandom % 2);
      wc = 8'hf8 + 8'($urandom % 7);
      wr(sms_pkg::PDC_OFS, 32'h0000_001f);
      wr(sms_pkg::WCS_OFS, 32'h0000_0020);
      wr(sms_pkg::PDC_OFS, 32'h0000_009f);
      rdc(sms_pkg::PDC_OFS, 32'h0000_001f);
      wr(sms_pkg::WCS_OFS, 32'h0000_0040 | cks);
      wr(sms_pkg::WCNT_OFS, {24'h0, wc});
      wr(sms_pkg::ICR_OFS, 32'(i));
      wr(sms_pkg::WRC_OFS, $urandom & 32'h0000_00ff);
      cpu.set_nmi(!i[0]);
      pdc = 32'h0000_009f | {port_float_bit, 6'h00};
      wr(sms_pkg::PDC_OFS, pdc);
      cpu.sleep;
      @(posedge pclk);
      #1 chk({cpu_halt, sys_clk_en, wdt_clk_en, periph_halt, standby_active},
             {1'b1, 1'b0, 1'b0, 1'b1, 1'b1});
      chk({port_hold, port_float}, {!port_float_bit, port_float_bit});
      rdc(sms_pkg::STAT_OFS, 32'h0000_0001);
      wr(sms_pkg::ICR_OFS, 32'(!i[0]));
      cpu.sleep;
      #1 chk(cpu_halt, 1'b1);
      cpu.set_nmi(i[0]);
      n = 0;
      while (nmi_exception !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      e = exp_cyc(wc, cks);
      // The prescaler phase at wake-up is free, so the first tick may come
      // up to one period early.
      chk(n >= e - (2 << cks) + 3 && n <= e + 2, 1'b1);
      #1 chk({sys_clk_en, wdt_clk_en, cpu_halt, periph_halt, port_hold,
              port_float}, 6'h30);
      rdc(sms_pkg::WCS_OFS, {29'h0, cks});
      rdc(sms_pkg::WRC_OFS, 32'h0000_0000);
      rdc(sms_pkg::PDC_OFS, pdc);
      rdc(sms_pkg::ICR_OFS, 32'(i));
      cpu.sleep;
      cpu.mreset;
      @(posedge pclk);
      #1 chk(cpu_halt, 1'b0);
    end
    cpu.sleep;
    repeat (2) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1 chk(cpu_halt, 1'b0);
    rdc(sms_pkg::PDC_OFS, 32'h0000_001f);
    finish_test;
  end
endmodule
`default_nettype wire
